/* File: hw/ieyb_dev_end.sv */
// Endpoint configuration bytes and IN token answer logic of the buffer manager
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module ieyb_dev_end
  import ieyb_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Configuration byte port
  ieyb_if.dev                    cfg,
  // IN token from the serial engine
  input  wire logic              tokValid,
  input  wire logic [EP_W-1:0]   tokEp,
  // Successful IN completion (host acknowledged the data)
  input  wire logic              doneValid,
  input  wire logic [EP_W-1:0]   doneEp,
  // Answer to the token
  output logic                   ansValid,
  output logic [EP_W-1:0]        ansEp,
  output logic                   ansNak,
  output logic                   ansIgnore,
  output logic [BCNT_W-1:0]      ansByteCnt
);

  // Configuration byte store, one group of eight per endpoint
  logic [7:0]        cfgMem_q [NUM_CFG];

  // Read-back flops toward the controller
  logic [7:0]        cfgRdData_q;
  logic              cfgRdValid_q;

  // Answer flops toward the serial engine
  logic              ansValid_q;
  logic [EP_W-1:0]   ansEp_q;
  logic              ansNak_q;
  logic              ansIgnore_q;
  logic [BCNT_W-1:0] ansByteCnt_q;

  // Per-endpoint decision, one entry per endpoint
  logic [NUM_EP-1:0] epEnabled;
  logic [NUM_EP-1:0] epIso;
  logic [NUM_EP-1:0] epNak;
  logic [BCNT_W-1:0] epByteCnt [NUM_EP];

  // Decision of the endpoint that the token names
  logic              tokEnabled;
  logic              tokNak_d;
  logic [BCNT_W-1:0] tokByteCnt_d;

  // One register per byte; the Y count byte also carries the hardware-set flag
  generate
    for (genvar i = 0; i < NUM_CFG; i++) begin : gByte
      localparam logic [CFG_AW-1:0] ADDR_I = CFG_AW'(i);
      localparam logic [EP_W-1:0]   EP_I   = EP_W'(i / BYTES_PER_EP);
      localparam bit                IS_YC  = ((i % BYTES_PER_EP) == int'(EPB_YCOUNT));
      localparam logic [7:0]        RST_I  = IS_YC ? RST_YCOUNT : RST_OTHER;
      logic                         wrHit;
      logic                         doneHit;

      // Strobes decoded for this byte alone
      assign wrHit   = cfg.cfgWrEn && (cfg.cfgAddr == ADDR_I);
      assign doneHit = IS_YC && doneValid && (doneEp == EP_I);

      // The byte itself; Y count bytes start with the buffer empty
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cfgMem_q[i] <= RST_I;
        end else begin
          // Firmware write stores the whole byte, the flag bit taken from the written data
          if (wrHit) begin
            cfgMem_q[i] <= cfg.cfgWrData;
          end
          // Completion wins over a firmware clear in the same cycle: losing a
          // completion would let a drained buffer be sent a second time
          if (doneHit) begin
            cfgMem_q[i][YC_EMPTY_BIT] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Each endpoint's answer is worked out all the time, so a token only
  // selects one; this keeps the token path a plain mux
  generate
    for (genvar e = 0; e < NUM_EP; e++) begin : gEp
      localparam int unsigned CFG_I  = e * BYTES_PER_EP + int'(EPB_CONFIG);
      localparam int unsigned YC_I   = e * BYTES_PER_EP + int'(EPB_YCOUNT);
      localparam bit          IS_CTL = (e == 0);
      // Local field views
      logic [YC_CNT_W-1:0]    count;
      logic [BPS_W:0]         sampleBytes;
      logic [BCNT_W-1:0]      isoBytes;

      // Fields of the endpoint's configuration and Y count bytes
      assign count    = cfgMem_q[YC_I][YC_CNT_W-1:0];
      assign epIso[e] = cfgMem_q[CFG_I][CFG_ISO_BIT];
      // The control endpoint cannot be switched off
      assign epEnabled[e] = cfgMem_q[CFG_I][CFG_EN_BIT] || IS_CTL;

      // Code 0 stands for one byte, hence the extra bit
      assign sampleBytes = {1'b0, cfgMem_q[CFG_I][BPS_MSB:0]} + (BPS_W+1)'(1);
      // Largest product is 127 samples of 32 bytes, inside 12 bits
      assign isoBytes = BCNT_W'(count) * BCNT_W'(sampleBytes);

      // Iso never NAKs: the empty flag only gates the other types
      assign epNak[e]     = !epIso[e] && cfgMem_q[YC_I][YC_EMPTY_BIT];
      assign epByteCnt[e] = epIso[e] ? isoBytes : BCNT_W'(count);
    end
  endgenerate

  // Pick the decision of the endpoint that the token names; a token in the
  // same cycle as a completion still sees the flag as it was
  always_comb begin
    tokEnabled   = epEnabled[tokEp];
    tokNak_d     = epNak[tokEp];
    tokByteCnt_d = epByteCnt[tokEp];
  end

  // Read-back strobe: answered exactly one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgRdValid_q <= 1'b0;
    end else begin
      cfgRdValid_q <= cfg.cfgRdEn;
    end
  end

  // Read-back data held until the next read, so a late look still sees it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgRdData_q <= 8'h00;
    end else if (cfg.cfgRdEn) begin
      cfgRdData_q <= cfgMem_q[cfg.cfgAddr];
    end
  end

  // Answer strobe: one cycle after each token, back to back allowed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ansValid_q <= 1'b0;
    end else begin
      ansValid_q <= tokValid;
    end
  end

  // Endpoint of the answer, held until the next token
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ansEp_q <= '0;
    end else if (tokValid) begin
      ansEp_q <= tokEp;
    end
  end

  // A disabled endpoint gives no handshake at all; the serial engine
  // simply lets the host time out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ansIgnore_q <= 1'b0;
    end else if (tokValid) begin
      ansIgnore_q <= ~tokEnabled;
    end
  end

  // NAK only from an enabled endpoint whose buffer is empty, never
  // together with the ignore flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ansNak_q <= 1'b0;
    end else if (tokValid) begin
      ansNak_q <= tokEnabled & tokNak_d;
    end
  end

  // Byte count reported only when data will actually go out; zero otherwise
  // keeps a stale count from looking like a packet after a NAK
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ansByteCnt_q <= '0;
    end else if (tokValid) begin
      if (tokEnabled && !tokNak_d) begin
        ansByteCnt_q <= tokByteCnt_d;
      end else begin
        ansByteCnt_q <= '0;
      end
    end
  end

  // Outputs straight from flops, so the far ends see no decode glitches
  assign cfg.cfgRdData  = cfgRdData_q;
  assign cfg.cfgRdValid = cfgRdValid_q;
  assign ansValid       = ansValid_q;
  assign ansEp          = ansEp_q;
  assign ansNak         = ansNak_q;
  assign ansIgnore      = ansIgnore_q;
  assign ansByteCnt     = ansByteCnt_q;

endmodule : ieyb_dev_end

/* File: hw/ieyb_pkg.sv */
// Shared constants for the IN endpoint Y buffer count logic and its controller
package ieyb_pkg;

  // Endpoint geometry: control endpoint plus seven IN endpoints, eight bytes each
  localparam int unsigned NUM_EP       = 8;
  localparam int unsigned EP_W         = 3;
  localparam int unsigned BYTES_PER_EP = 8;
  localparam int unsigned BYTE_W       = 3;
  localparam int unsigned CFG_AW       = EP_W + BYTE_W;
  localparam int unsigned NUM_CFG      = NUM_EP * BYTES_PER_EP;

  // Byte positions inside one endpoint's group
  localparam logic [BYTE_W-1:0] EPB_CONFIG = 3'h0;
  localparam logic [BYTE_W-1:0] EPB_YCOUNT = 3'h6;

  // Field positions of the endpoint configuration byte
  localparam int unsigned CFG_EN_BIT  = 7;
  localparam int unsigned CFG_ISO_BIT = 6;
  localparam int unsigned BPS_MSB     = 4;
  localparam int unsigned BPS_W       = 5;

  // Field positions of the Y count byte
  localparam int unsigned YC_EMPTY_BIT = 7;
  localparam int unsigned YC_CNT_W     = 7;

  // Byte count of one packet: 127 samples of up to 32 bytes
  localparam int unsigned BCNT_W = 12;

  // Reset values: Y buffer starts empty, other bytes clear
  localparam logic [7:0] RST_YCOUNT = 8'h80;
  localparam logic [7:0] RST_OTHER  = 8'h00;

  // Controller APB register offsets
  localparam logic [7:0] REG_ADDR  = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDCMD = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_LOAD  = 8'h10;

  // Read data valid flag position in the read-back register
  localparam int unsigned RDATA_VALID_BIT = 8;

endpackage : ieyb_pkg

/* File: hw/ieyb_if.sv */
// Configuration byte port between the controller and the endpoint logic
`timescale 1ns/1ps
interface ieyb_if;
  import ieyb_pkg::*;

  logic              cfgWrEn;
  logic              cfgRdEn;
  logic [CFG_AW-1:0] cfgAddr;
  logic [7:0]        cfgWrData;
  logic [7:0]        cfgRdData;
  logic              cfgRdValid;

  // Endpoint logic end
  modport dev (
    input  cfgWrEn,
    input  cfgRdEn,
    input  cfgAddr,
    input  cfgWrData,
    output cfgRdData,
    output cfgRdValid
  );

  // Controller end
  modport ctl (
    output cfgWrEn,
    output cfgRdEn,
    output cfgAddr,
    output cfgWrData,
    input  cfgRdData,
    input  cfgRdValid
  );

endinterface : ieyb_if

/* File: hw/ieyb_ctl_end.sv */
// Processor-side controller: APB registers that drive the configuration byte port
`timescale 1ns/1ps
module ieyb_ctl_end
  import ieyb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Configuration byte port
  ieyb_if.ctl              cfg
);

  logic [CFG_AW-1:0] addr_q;
  logic [7:0]        wdata_q;
  logic [7:0]        rdata_q;
  logic              rdValid_q;
  logic              cfgWrEn_q;
  logic              cfgRdEn_q;
  logic [CFG_AW-1:0] cfgAddr_q;
  logic [7:0]        cfgWrData_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              setup;
  logic              access;
  logic              mapped;
  logic [31:0]       rdMux;

  // Setup sampled first; ready follows in the first access cycle, zero wait
  assign setup  = psel && !penable && !pready_q;
  assign access = psel && penable && pready_q;

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h0000_0000;
    case (paddr)
      REG_ADDR:  rdMux = 32'(addr_q);
      REG_WDATA: rdMux = 32'(wdata_q);
      REG_RDCMD: rdMux = 32'h0000_0000;
      REG_RDATA: rdMux = 32'({rdValid_q, rdata_q});
      REG_LOAD:  rdMux = 32'h0000_0000;
      default:   mapped = 1'b0;
    endcase
  end

  // APB answer flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= (setup && !pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // Software registers and configuration port requests
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_q      <= '0;
      wdata_q     <= 8'h00;
      cfgWrEn_q   <= 1'b0;
      cfgRdEn_q   <= 1'b0;
      cfgAddr_q   <= '0;
      cfgWrData_q <= 8'h00;
    end else begin
      cfgWrEn_q <= 1'b0;
      cfgRdEn_q <= 1'b0;
      if (access && pwrite) begin
        case (paddr)
          REG_ADDR: begin
            addr_q <= pwdata[CFG_AW-1:0];
          end
          REG_WDATA: begin
            wdata_q     <= pwdata[7:0];
            cfgWrEn_q   <= 1'b1;
            cfgAddr_q   <= addr_q;
            cfgWrData_q <= pwdata[7:0];
          end
          REG_RDCMD: begin
            cfgRdEn_q <= 1'b1;
            cfgAddr_q <= addr_q;
          end
          REG_LOAD: begin
            // New packet: count written with the empty flag cleared in one go
            cfgWrEn_q   <= 1'b1;
            cfgAddr_q   <= {addr_q[CFG_AW-1:BYTE_W], EPB_YCOUNT};
            cfgWrData_q <= {1'b0, pwdata[YC_CNT_W-1:0]};
          end
          default: begin
            cfgWrEn_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Read-back capture; a new read command drops the stale valid flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q   <= 8'h00;
      rdValid_q <= 1'b0;
    end else if (cfg.cfgRdValid) begin
      rdata_q   <= cfg.cfgRdData;
      rdValid_q <= 1'b1;
    end else if (cfgRdEn_q) begin
      rdValid_q <= 1'b0;
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign cfg.cfgWrEn   = cfgWrEn_q;
  assign cfg.cfgRdEn   = cfgRdEn_q;
  assign cfg.cfgAddr   = cfgAddr_q;
  assign cfg.cfgWrData = cfgWrData_q;

endmodule : ieyb_ctl_end

/* File: sim/ieyb_cfg_monitor.sv */
// Checker for the configuration byte port between the two ends
`timescale 1ns/1ps
module ieyb_cfg_monitor
  import ieyb_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // Configuration byte port
  input wire logic              cfgWrEn,
  input wire logic              cfgRdEn,
  input wire logic [CFG_AW-1:0] cfgAddr,
  input wire logic [7:0]        cfgWrData,
  input wire logic [7:0]        cfgRdData,
  input wire logic              cfgRdValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [7:0]        shadow_q [NUM_CFG];
  logic [CFG_AW-1:0] rdAddr_q;

  // Shadow of written bytes; completions may also set the empty flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        shadow_q[i] <= ((i % BYTES_PER_EP) == int'(EPB_YCOUNT)) ? RST_YCOUNT : RST_OTHER;
      end
    end else if (cfgWrEn) begin
      shadow_q[cfgAddr] <= cfgWrData;
    end
  end

  // Address of the read in flight
  always_ff @(posedge clk) begin
    if (cfgRdEn) begin
      rdAddr_q <= cfgAddr;
    end
  end

  a_rd_answer: assert property (cfgRdEn |=> cfgRdValid)
    else $error("read not answered next cycle");
  a_rd_cause: assert property (cfgRdValid |-> $past(cfgRdEn))
    else $error("read data without request");
  a_valid_pulse: assert property (cfgRdValid |=> !cfgRdValid)
    else $error("read valid longer than one cycle");
  a_wr_pulse: assert property (cfgWrEn |=> !cfgWrEn)
    else $error("write strobe longer than one cycle");
  a_rd_pulse: assert property (cfgRdEn |=> !cfgRdEn)
    else $error("read strobe longer than one cycle");
  a_one_strobe: assert property (!(cfgWrEn && cfgRdEn))
    else $error("read and write strobes together");
  a_cfg_keep: assert property (cfgRdValid && rdAddr_q[BYTE_W-1:0] != EPB_YCOUNT
    |-> cfgRdData == shadow_q[rdAddr_q])
    else $error("config byte differs from last write");
  a_count_keep: assert property (cfgRdValid && rdAddr_q[BYTE_W-1:0] == EPB_YCOUNT
    |-> cfgRdData[YC_CNT_W-1:0] == shadow_q[rdAddr_q][YC_CNT_W-1:0])
    else $error("count field differs from last write");

  c_write: cover property (cfgWrEn);
  c_count_read: cover property (cfgRdValid && rdAddr_q[BYTE_W-1:0] == EPB_YCOUNT);
  c_two_writes: cover property (cfgWrEn ##2 cfgWrEn);
endmodule : ieyb_cfg_monitor

/* File: sim/in_endpoint_y_buffer_count_tb.sv */
// Self-checking bench joining both ends of the Y buffer count logic
`timescale 1ns/1ps
module in_endpoint_y_buffer_count_tb
  import ieyb_pkg::*;
;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic tokValid, doneValid, ansValid, ansNak, ansIgnore;
  logic [7:0] paddr, c;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] tokEp, doneEp, ansEp, e;
  logic [6:0] n;
  logic [11:0] ansByteCnt;
  logic [7:0] cfgM [NUM_EP];
  logic [7:0] yM [NUM_EP];
  int failures, checkCount;

  ieyb_if u_ieyb_if ();
  ieyb_ctl_end u_ieyb_ctl_end (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(u_ieyb_if));
  ieyb_dev_end u_ieyb_dev_end (.clk(clk), .sys_rst(sys_rst), .cfg(u_ieyb_if),
    .tokValid(tokValid), .tokEp(tokEp), .doneValid(doneValid), .doneEp(doneEp),
    .ansValid(ansValid), .ansEp(ansEp), .ansNak(ansNak), .ansIgnore(ansIgnore),
    .ansByteCnt(ansByteCnt));
  ieyb_cfg_monitor u_ieyb_cfg_monitor (.clk(clk), .sys_rst(sys_rst),
    .cfgWrEn(u_ieyb_if.cfgWrEn), .cfgRdEn(u_ieyb_if.cfgRdEn), .cfgAddr(u_ieyb_if.cfgAddr),
    .cfgWrData(u_ieyb_if.cfgWrData), .cfgRdData(u_ieyb_if.cfgRdData),
    .cfgRdValid(u_ieyb_if.cfgRdValid));

  // Verdict and end of run
  task automatic results();
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic miss(input string m);
    failures++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : miss

  // Compare tasks, one per kind of result
  task automatic chkByte(input logic [7:0] g, input logic [7:0] x);
    checkCount++;
    if (g !== x) miss("byte");
  endtask : chkByte

  task automatic chkAns(input logic [17:0] g, input logic [17:0] x);
    checkCount++;
    if (g !== x) miss("token answer");
  endtask : chkAns

  task automatic chkErr(input logic g, input logic x);
    checkCount++;
    if (g !== x) miss("slave error");
  endtask : chkErr

  // One APB transfer; ready, read data and error are taken at one rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    logic ok;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    ok = 1'b0;
    while (!ok) begin
      @(posedge clk);
      k++;
      // Flop outputs still show their values from before this edge
      ok = (pready === 1'b1);
      if (!ok && k > 20) begin
        miss("apb timeout");
        results();
      end
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Byte read through the controller, polling the valid flag
  task automatic rdByte(input logic [7:0] a);
    int k;
    apb(REG_ADDR, 1'b1, {24'h00_0000, a});
    apb(REG_RDCMD, 1'b1, 32'h0000_0000);
    k = 0;
    rd = 32'h0000_0000;
    while (rd[RDATA_VALID_BIT] !== 1'b1) begin
      apb(REG_RDATA, 1'b0, 32'h0000_0000);
      k++;
      if (k > 10) begin
        miss("read timeout");
        results();
      end
    end
  endtask : rdByte

  // Expected {nak, ignore, byte count} from the bench's copy of the bytes
  function automatic logic [13:0] expAns(input logic [2:0] p);
    if (!(cfgM[p][CFG_EN_BIT] || p == 3'h0)) return 14'h1000;
    if (cfgM[p][CFG_ISO_BIT]) return {2'b00, 12'(int'(yM[p][6:0]) * (int'(cfgM[p][4:0]) + 1))};
    if (yM[p][YC_EMPTY_BIT]) return 14'h2000;
    return {7'h00, yM[p][6:0]};
  endfunction : expAns

  task automatic token(input logic [2:0] p);
    logic [13:0] x;
    x = expAns(p);
    tokValid <= 1'b1;
    tokEp <= p;
    @(posedge clk);
    tokValid <= 1'b0;
    @(negedge clk);
    chkAns({ansValid, ansNak, ansIgnore, ansEp, ansByteCnt}, {1'b1, x[13:12], p, x[11:0]});
    @(posedge clk);
  endtask : token

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Main sequence
  initial begin
    {sys_rst, psel, penable, pwrite, tokValid, doneValid} = 6'h01 << 5;
    {paddr, pwdata, tokEp, doneEp} = '0;
    failures = 0;
    checkCount = 0;
    for (int i = 0; i < NUM_EP; i++) begin
      cfgM[i] = RST_OTHER;
      yM[i] = RST_YCOUNT;
    end
    void'($urandom(32'h20c1_d56c));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdByte({3'h3, EPB_YCOUNT});
    chkByte(rd[7:0], RST_YCOUNT);
    token(3'h0);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      e = 3'($urandom_range(7, 0));
      c = 8'($urandom) & 8'hDF;
      n = 7'($urandom);
      if (i == 0) {c, n} = {8'hDF, 7'h7F};
      if (i == 1) {c, n} = {8'h80, 7'h00};
      apb(REG_ADDR, 1'b1, {26'h000_0000, e, EPB_CONFIG});
      apb(REG_WDATA, 1'b1, {24'h00_0000, c});
      cfgM[e] = c;
      apb(REG_LOAD, 1'b1, {25'h000_0000, n});
      yM[e] = {1'b0, n};
      token(e);
      doneValid <= 1'b1;
      doneEp <= e;
      @(posedge clk);
      doneValid <= 1'b0;
      yM[e][YC_EMPTY_BIT] = 1'b1;
      token(e);
      rdByte({e, EPB_YCOUNT});
      chkByte(rd[7:0], yM[e]);
      rdByte({e, EPB_CONFIG});
      chkByte(rd[7:0], cfgM[e]);
    end
    $display("test random done");
    apb(8'h14, 1'b0, 32'h0000_0000);
    chkErr(er, 1'b1);
    chkByte(rd[7:0], 8'h00);
    apb(REG_ADDR, 1'b0, 32'h0000_0000);
    chkErr(er, 1'b0);
    chkByte(rd[7:0], {2'b00, e, EPB_CONFIG});
    $display("test unmapped done");
    results();
  end
endmodule : in_endpoint_y_buffer_count_tb
